// ===== dss_pkg.sv
package dss_pkg;
	localparam int unsigned ADDR_W = 12;
	localparam logic [11:0] OFS_POWERUP_STATUS = 12'h000;
	localparam logic [11:0] OFS_STOP_CONTROL = 12'h010;
	localparam int unsigned BIT_PWR_REQ = 28;
	localparam int unsigned BIT_PWR_ACK = 29;
	localparam int unsigned BIT_WATCHDOG = 0;
	localparam int unsigned BIT_RSVD_ONE = 1;
	localparam int unsigned BIT_TIMER_GRP = 14;
	localparam int unsigned BIT_SERIAL_GRP = 15;
	localparam int unsigned BIT_VDET0 = 16;
	localparam int unsigned BIT_VDET1 = 17;
	localparam int unsigned BIT_RAM_PAR = 24;
	localparam logic [31:0] STOP_CTRL_RESET = 32'h0000_0003;
	localparam logic [31:0] STOP_CTRL_WMASK = 32'h0103_c001;
	localparam logic [31:0] STOP_CTRL_FIXED = 32'h0000_0002;
	localparam int unsigned PWR_SETTLE_CYCLES = 4;

	typedef struct packed {
		logic watchdog;
		logic timer_group;
		logic serial_irq_group;
		logic voltage_detect0;
		logic voltage_detect1;
		logic ram_parity;
	} dss_stop_t;

	typedef struct packed {
		logic sel;
		logic write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} dss_bus_req_t;
endpackage

// ===== dss_sync2.sv
module dss_sync2 (
	input wire logic clock,
	input wire logic reset,
	input wire logic async_in,
	output logic sync_out
);
	logic stage1_reg;
	logic stage1_next;
	logic stage2_reg;
	logic stage2_next;

	always_comb begin
		stage1_next = async_in;
		stage2_next = stage1_reg;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			stage1_reg <= 1'b0;
			stage2_reg <= 1'b0;
		end else begin
			stage1_reg <= stage1_next;
			stage2_reg <= stage2_next;
		end
	end

	assign sync_out = stage2_reg;
endmodule

// ===== dss_power_handshake.sv
module dss_power_handshake #(
	parameter int unsigned SETTLE = dss_pkg::PWR_SETTLE_CYCLES
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic request,
	input wire logic domain_powered,
	output logic acknowledge
);
	logic ack_reg;
	logic ack_next;
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;

	// Acknowledge waits for request plus a stable powered domain
	always_comb begin
		ack_next = ack_reg;
		cnt_next = cnt_reg;
		if (!request || !domain_powered) begin
			cnt_next = 8'h00;
			ack_next = 1'b0;
		end else if (cnt_reg < 8'(SETTLE)) begin
			cnt_next = cnt_reg + 8'h01;
		end else begin
			ack_next = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ack_reg <= 1'b0;
			cnt_reg <= 8'h00;
		end else begin
			ack_reg <= ack_next;
			cnt_reg <= cnt_next;
		end
	end

	assign acknowledge = ack_reg;
endmodule

// ===== dss_debug_stop_status_regs.sv
module dss_debug_stop_status_regs (
	input wire logic clock,
	input wire logic reset,
	input dss_pkg::dss_bus_req_t bus_req,
	output logic [31:0] bus_rdata,
	output logic bus_error,
	input wire logic dbg_power_request,
	input wire logic debug_domain_powered,
	input wire logic debug_mode,
	input wire logic debug_break,
	output logic dbg_power_acknowledge,
	output dss_pkg::dss_stop_t stop_masks
);
	logic req_sync;
	logic pwr_sync;
	logic ack_raw;
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic err_reg;
	logic err_next;
	logic ack_reg;
	logic ack_next;
	dss_pkg::dss_stop_t stop_reg;
	dss_pkg::dss_stop_t stop_next;
	logic [31:0] status_word;

	// Emulator request and power-good come from outside this clock
	dss_sync2 u_req_sync (
		.clock(clock),
		.reset(reset),
		.async_in(dbg_power_request),
		.sync_out(req_sync)
	);

	dss_sync2 u_pwr_sync (
		.clock(clock),
		.reset(reset),
		.async_in(debug_domain_powered),
		.sync_out(pwr_sync)
	);

	dss_power_handshake u_handshake (
		.clock(clock),
		.reset(reset),
		.request(req_sync),
		.domain_powered(pwr_sync),
		.acknowledge(ack_raw)
	);

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[dss_pkg::BIT_PWR_REQ] = req_sync;
		status_word[dss_pkg::BIT_PWR_ACK] = ack_raw;
	end

	// Register access: read data and error registered one cycle after select
	always_comb begin
		ctrl_next = ctrl_reg;
		rdata_next = 32'h0000_0000;
		err_next = 1'b0;
		if (bus_req.sel) begin
			if (bus_req.addr == dss_pkg::OFS_POWERUP_STATUS) begin
				if (!bus_req.write) begin
					rdata_next = status_word;
				end
				// Writes here fall through with no effect
			end else if (bus_req.addr == dss_pkg::OFS_STOP_CONTROL) begin
				if (bus_req.write) begin
					// Reserved bits held at fixed values whatever is written
					ctrl_next = (bus_req.wdata & dss_pkg::STOP_CTRL_WMASK)
						| dss_pkg::STOP_CTRL_FIXED;
				end else begin
					rdata_next = ctrl_reg;
				end
			end else begin
				err_next = 1'b1;
			end
		end
	end

	// Effective masks; all zero unless the chip is in debug mode
	always_comb begin
		stop_next = '0;
		if (debug_mode) begin
			stop_next.watchdog = ctrl_reg[dss_pkg::BIT_WATCHDOG] | debug_break;
			stop_next.timer_group = ctrl_reg[dss_pkg::BIT_TIMER_GRP] & debug_break;
			stop_next.serial_irq_group = ctrl_reg[dss_pkg::BIT_SERIAL_GRP] & debug_break;
			stop_next.voltage_detect0 = ctrl_reg[dss_pkg::BIT_VDET0];
			stop_next.voltage_detect1 = ctrl_reg[dss_pkg::BIT_VDET1];
			stop_next.ram_parity = ctrl_reg[dss_pkg::BIT_RAM_PAR];
		end
		ack_next = ack_raw;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ctrl_reg <= dss_pkg::STOP_CTRL_RESET;
			rdata_reg <= 32'h0000_0000;
			err_reg <= 1'b0;
			stop_reg <= '0;
			ack_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			rdata_reg <= rdata_next;
			err_reg <= err_next;
			stop_reg <= stop_next;
			ack_reg <= ack_next;
		end
	end

	assign bus_rdata = rdata_reg;
	assign bus_error = err_reg;
	assign stop_masks = stop_reg;
	assign dbg_power_acknowledge = ack_reg;

	property p_status_read_bits;
		@(posedge clock) disable iff (reset)
		(bus_req.sel && !bus_req.write && bus_req.addr == dss_pkg::OFS_POWERUP_STATUS)
		|=> (bus_rdata[dss_pkg::BIT_PWR_REQ] == $past(req_sync))
		&& (bus_rdata[dss_pkg::BIT_PWR_ACK] == $past(ack_raw));
	endproperty
	a_status_read_bits: assert property (p_status_read_bits) else $error("status bits wrong");

	property p_status_reserved;
		@(posedge clock) disable iff (reset)
		(bus_req.sel && !bus_req.write && bus_req.addr == dss_pkg::OFS_POWERUP_STATUS)
		|=> (bus_rdata[27:0] == 28'h0000000) && (bus_rdata[31:30] == 2'h0);
	endproperty
	a_status_reserved: assert property (p_status_reserved) else $error("status reserved nonzero");

	property p_ack_follows;
		@(posedge clock) disable iff (reset)
		$rose(ack_raw) |-> $past(req_sync) && $past(pwr_sync);
	endproperty
	a_ack_follows: assert property (p_ack_follows) else $error("ack without request");

	property p_ack_drops;
		@(posedge clock) disable iff (reset)
		(!req_sync && ack_raw) |=> !ack_raw;
	endproperty
	a_ack_drops: assert property (p_ack_drops) else $error("ack held after request gone");

	property p_outside_debug;
		@(posedge clock) disable iff (reset)
		!debug_mode |=> (stop_masks == '0);
	endproperty
	a_outside_debug: assert property (p_outside_debug) else $error("mask outside debug mode");

	property p_break_watchdog;
		@(posedge clock) disable iff (reset)
		(debug_mode && debug_break) |=> stop_masks.watchdog;
	endproperty
	a_break_watchdog: assert property (p_break_watchdog) else $error("watchdog not stopped");

	property p_run_watchdog;
		@(posedge clock) disable iff (reset)
		(debug_mode && !debug_break)
		|=> (stop_masks.watchdog == $past(ctrl_reg[dss_pkg::BIT_WATCHDOG]));
	endproperty
	a_run_watchdog: assert property (p_run_watchdog) else $error("watchdog run mask wrong");

	property p_timer_run;
		@(posedge clock) disable iff (reset)
		!debug_break |=> !stop_masks.timer_group && !stop_masks.serial_irq_group;
	endproperty
	a_timer_run: assert property (p_timer_run) else $error("group stopped outside break");

	property p_ctrl_fixed;
		@(posedge clock) disable iff (reset)
		(bus_req.sel && bus_req.write && bus_req.addr == dss_pkg::OFS_STOP_CONTROL)
		|=> ((ctrl_reg & ~dss_pkg::STOP_CTRL_WMASK) == dss_pkg::STOP_CTRL_FIXED);
	endproperty
	a_ctrl_fixed: assert property (p_ctrl_fixed) else $error("reserved control bits wrong");

	property p_status_write;
		@(posedge clock) disable iff (reset)
		(bus_req.sel && bus_req.write && bus_req.addr == dss_pkg::OFS_POWERUP_STATUS)
		|=> $stable(ctrl_reg) && !bus_error;
	endproperty
	a_status_write: assert property (p_status_write) else $error("status write had effect");

	// Output acknowledge is the handshake result, one register later
	property p_ack_out_rise;
		@(posedge clock) disable iff (reset)
		ack_raw
		|=> dbg_power_acknowledge;
	endproperty
	a_ack_out_rise: assert property (p_ack_out_rise) else $error("ack output low");

	property p_ack_out_fall;
		@(posedge clock) disable iff (reset)
		!ack_raw
		|=> !dbg_power_acknowledge;
	endproperty
	a_ack_out_fall: assert property (p_ack_out_fall) else $error("ack out high");

	// A collapsing synchronised debug supply must withdraw the handshake acknowledge one clock later
	property p_ack_no_power;
		@(posedge clock) disable iff (reset)
		(!pwr_sync && ack_raw)
		|=> !ack_raw;
	endproperty
	a_ack_no_power: assert property (p_ack_no_power) else $error("ack unpowered");

	property p_ack_settle;
		@(posedge clock) disable iff (reset)
		$rose(ack_raw)
		|-> $past(req_sync, 2) && $past(pwr_sync, 2);
	endproperty
	a_ack_settle: assert property (p_ack_settle) else $error("ack too early");

	property p_ack_out_drop;
		@(posedge clock) disable iff (reset)
		(!req_sync && ack_raw)
		|=> ##1 !dbg_power_acknowledge;
	endproperty
	a_ack_out_drop: assert property (p_ack_out_drop) else $error("ack out held");

	// Detector and parity masks follow their bits in run and break alike
	property p_vdet0_mask;
		@(posedge clock) disable iff (reset)
		debug_mode
		|=> (stop_masks.voltage_detect0 == $past(ctrl_reg[dss_pkg::BIT_VDET0]));
	endproperty
	a_vdet0_mask: assert property (p_vdet0_mask) else $error("vdet0 mask wrong");

	property p_vdet1_mask;
		@(posedge clock) disable iff (reset)
		debug_mode
		|=> (stop_masks.voltage_detect1 == $past(ctrl_reg[dss_pkg::BIT_VDET1]));
	endproperty
	a_vdet1_mask: assert property (p_vdet1_mask) else $error("vdet1 mask wrong");

	property p_ram_mask;
		@(posedge clock) disable iff (reset)
		debug_mode
		|=> (stop_masks.ram_parity == $past(ctrl_reg[dss_pkg::BIT_RAM_PAR]));
	endproperty
	a_ram_mask: assert property (p_ram_mask) else $error("parity mask wrong");

	property p_timer_break;
		@(posedge clock) disable iff (reset)
		(debug_mode && debug_break)
		|=> (stop_masks.timer_group == $past(ctrl_reg[dss_pkg::BIT_TIMER_GRP]));
	endproperty
	a_timer_break: assert property (p_timer_break) else $error("timer mask wrong");

	property p_serial_break;
		@(posedge clock) disable iff (reset)
		(debug_mode && debug_break)
		|=> (stop_masks.serial_irq_group == $past(ctrl_reg[dss_pkg::BIT_SERIAL_GRP]));
	endproperty
	a_serial_break: assert property (p_serial_break) else $error("serial mask bad");

	property p_serial_run;
		@(posedge clock) disable iff (reset)
		!debug_break
		|=> !stop_masks.serial_irq_group;
	endproperty
	a_serial_run: assert property (p_serial_run) else $error("serial stopped");

	// Control register keeps only its defined bits, reserved ones pinned
	property p_ctrl_write;
		@(posedge clock) disable iff (reset)
		(bus_req.sel && bus_req.write && bus_req.addr == dss_pkg::OFS_STOP_CONTROL)
		|=> (ctrl_reg == (($past(bus_req.wdata) & dss_pkg::STOP_CTRL_WMASK)
			| dss_pkg::STOP_CTRL_FIXED));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write wrong");

	property p_ctrl_read;
		@(posedge clock) disable iff (reset)
		(bus_req.sel && !bus_req.write && bus_req.addr == dss_pkg::OFS_STOP_CONTROL)
		|=> (bus_rdata == $past(ctrl_reg));
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

	property p_ctrl_keep;
		@(posedge clock) disable iff (reset)
		(bus_req.sel && bus_req.addr != dss_pkg::OFS_STOP_CONTROL)
		|=> $stable(ctrl_reg);
	endproperty
	a_ctrl_keep: assert property (p_ctrl_keep) else $error("control changed");

	property p_status_wdata;
		@(posedge clock) disable iff (reset)
		(bus_req.sel && bus_req.write && bus_req.addr == dss_pkg::OFS_POWERUP_STATUS)
		|=> (bus_rdata == 32'h0000_0000);
	endproperty
	a_status_wdata: assert property (p_status_wdata) else $error("write data shown");

	property p_status_ok;
		@(posedge clock) disable iff (reset)
		(bus_req.sel && !bus_req.write && bus_req.addr == dss_pkg::OFS_POWERUP_STATUS)
		|=> !bus_error;
	endproperty
	a_status_ok: assert property (p_status_ok) else $error("status read error");
endmodule

// ===== dss_emu_model.sv
module dss_emu_model (
	input wire logic clock,
	input wire logic want,
	input wire logic block_power,
	output logic dbg_power_request,
	output logic debug_domain_powered
);
	timeunit 1ns;
	timeprecision 1ns;
	logic req_q = 1'b0;
	logic good_q = 1'b0;
	logic [2:0] up_count = 3'h0;
	// Power-good lags the request like a slow supply; block_power models a dead domain
	always @(posedge clock) begin
		req_q <= #1 want;
		if (!want || block_power)
			up_count <= 3'h0;
		else if (up_count != 3'h7)
			up_count <= up_count + 3'h1;
		good_q <= #1 (up_count == 3'h7);
	end
	assign dbg_power_request = req_q;
	assign debug_domain_powered = good_q;
endmodule

// ===== tb_debug_stop_status_regs.sv
module tb_debug_stop_status_regs;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic reset = 1'b1;
	dss_pkg::dss_bus_req_t bus_req = '0;
	logic [31:0] bus_rdata, r;
	logic bus_error, e;
	logic want = 1'b0;
	logic block_power = 1'b0;
	logic debug_mode = 1'b0;
	logic debug_break = 1'b0;
	logic dbg_power_request, debug_domain_powered, ack;
	dss_pkg::dss_stop_t stop_masks;
	int err_count = 0;
	int n_tests = 0;
	dss_debug_stop_status_regs dut (.clock(clock), .reset(reset), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .bus_error(bus_error), .dbg_power_request(dbg_power_request),
		.debug_domain_powered(debug_domain_powered), .debug_mode(debug_mode),
		.debug_break(debug_break), .dbg_power_acknowledge(ack), .stop_masks(stop_masks));
	dss_emu_model emu (.clock(clock), .want(want), .block_power(block_power),
		.dbg_power_request(dbg_power_request), .debug_domain_powered(debug_domain_powered));
	initial begin
		forever #25 clock = ~clock;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task conclude;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Entered and left just after a rising edge; leaves one idle cycle behind
	task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		bus_req = '{1'b1, w, a, d};
		@(posedge clock);
		#1;
		r = bus_rdata;
		e = bus_error;
		bus_req.sel = 1'b0;
		@(posedge clock);
		#1;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0);
		check(r, exp);
	endtask
	task poll(input logic [31:0] exp);
		acc(1'b0, dss_pkg::OFS_POWERUP_STATUS, 32'h0);
		for (int i = 0; i < 40 && r !== exp; i++)
			acc(1'b0, dss_pkg::OFS_POWERUP_STATUS, 32'h0);
	endtask
	task t_regs;
		rd(dss_pkg::OFS_STOP_CONTROL, 32'h0000_0003);
		rd(dss_pkg::OFS_POWERUP_STATUS, 32'h0);
		check({26'h0, stop_masks}, 32'h0);
		acc(1'b1, dss_pkg::OFS_POWERUP_STATUS, 32'hffff_ffff);
		check({31'h0, e}, 32'h0);
		check(r, 32'h0);
		rd(dss_pkg::OFS_POWERUP_STATUS, 32'h0);
		// Software keeps bit 1 at one and reserved bits at zero
		acc(1'b1, dss_pkg::OFS_STOP_CONTROL, 32'h0103_c003);
		rd(dss_pkg::OFS_STOP_CONTROL, 32'h0103_c003);
		acc(1'b1, dss_pkg::OFS_STOP_CONTROL, 32'h0000_0002);
		rd(dss_pkg::OFS_STOP_CONTROL, 32'h0000_0002);
		acc(1'b0, 12'h020, 32'h0);
		check({31'h0, e}, 32'h1);
		check(r, 32'h0);
	endtask
	// Control value, mode and break levels, expected masks in struct order
	logic [31:0] ctab [11] = '{32'h0103_c003, 32'h0103_c003, 32'h0103_c003, 32'h2, 32'h2,
		32'h1_0002, 32'h2_0002, 32'h100_0002, 32'h4002, 32'h4002, 32'h8002};
	logic [1:0] mtab [11] = '{2'h0, 2'h2, 2'h3, 2'h3, 2'h2, 2'h2, 2'h2, 2'h2, 2'h3, 2'h2, 2'h3};
	logic [5:0] etab [11] = '{6'h00, 6'h27, 6'h3f, 6'h20, 6'h00, 6'h04, 6'h02, 6'h01, 6'h30,
		6'h00, 6'h28};
	task t_masks;
		for (int i = 0; i < 11; i++) begin
			acc(1'b1, dss_pkg::OFS_STOP_CONTROL, ctab[i]);
			debug_mode = mtab[i][1];
			debug_break = mtab[i][0];
			@(posedge clock);
			#1;
			check({26'h0, stop_masks}, {26'h0, etab[i]});
			check({26'h0, stop_masks}, {26'h0, etab[i]});
		end
		debug_mode = 1'b0;
	endtask
	task t_power;
		block_power = 1'b1;
		want = 1'b1;
		repeat (30) @(posedge clock);
		#1;
		rd(dss_pkg::OFS_POWERUP_STATUS, 32'h1000_0000);
		check({31'h0, ack}, 32'h0);
		block_power = 1'b0;
		poll(32'h3000_0000);
		check(r, 32'h3000_0000);
		check({31'h0, ack}, 32'h1);
		// Supply loss with the request still up must withdraw the acknowledge
		block_power = 1'b1;
		poll(32'h1000_0000);
		check(r, 32'h1000_0000);
		check({31'h0, ack}, 32'h0);
		block_power = 1'b0;
		poll(32'h3000_0000);
		check(r, 32'h3000_0000);
		want = 1'b0;
		poll(32'h0);
		check(r, 32'h0);
		@(posedge clock);
		#1;
		check({31'h0, ack}, 32'h0);
	endtask
	initial begin
		repeat (4) @(posedge clock);
		#1;
		reset = 1'b0;
		t_regs;
		t_masks;
		t_power;
		conclude;
	end
	initial begin
		#200000;
		err_count++;
		conclude;
	end
endmodule
